// File: core/dtc_pkg.sv
// shared constants, types and the count-clock decode for the dual timer
package dtc_pkg;

  // channel count and data widths
  localparam int          NUM_CH      = 2;
  localparam int          DATA_W      = 8;
  localparam int          ADDR_W      = 16;
  localparam int          PRESC_W     = 13;

  // register byte addresses
  localparam logic [15:0] ADDR_TM5    = 16'hFF48;
  localparam logic [15:0] ADDR_TM6    = 16'hFF49;
  localparam logic [15:0] ADDR_CR5    = 16'hFF4A;
  localparam logic [15:0] ADDR_CR6    = 16'hFF4B;
  localparam logic [15:0] ADDR_TIMER5_CLOCK_SELECT   = 16'hFF52;
  localparam logic [15:0] ADDR_TIMER5_MODE_CONTROL   = 16'hFF53;
  localparam logic [15:0] ADDR_TIMER6_CLOCK_SELECT   = 16'hFF56;
  localparam logic [15:0] ADDR_TIMER6_MODE_CONTROL   = 16'hFF57;
  localparam logic [15:0] ADDR_PDIR   = 16'hFF2A;

  // mode control field positions and the clock select code msb
  localparam int          TCE_BIT     = 7;
  localparam int          PWM_BIT     = 6;
  localparam int          LVS_BIT     = 3;
  localparam int          LVR_BIT     = 2;
  localparam int          ALV_BIT     = 1;
  localparam int          TOE_BIT     = 0;
  localparam int          CODE_MSB    = 3;

  // reset values
  localparam logic [7:0]  CMP_RST     = 8'h00;
  localparam logic [7:0]  CNT_RST     = 8'h00;
  localparam logic [7:0]  TCL_RST     = 8'h00;
  localparam logic [7:0]  TMC_RST     = 8'h00;
  localparam logic [7:0]  PDIR_RST    = 8'hFF;
  localparam logic [7:0]  RD_IDLE     = 8'h00;

  // count clock codes and divider exponents
  localparam logic [3:0]  CODE_FALL   = 4'h0;
  localparam logic [3:0]  CODE_RISE   = 4'h1;
  localparam logic [3:0]  CODE_2FXX   = 4'h4;
  localparam logic [3:0]  CODE_FXX    = 4'h5;
  localparam logic [3:0]  CODE_TOP    = 4'hF;
  localparam logic [3:0]  TOP_EXP     = 4'hB;

  // per channel operating mode
  typedef struct packed {
    logic enable;
    logic pwm_mode;
    logic alt_level;
    logic out_en;
  } dtc_mode_s;

  // one-cycle count tick for a select code
  function automatic logic dtc_tick(input logic [3:0]         code,
                                    input logic               oscillation_mode_bit,
                                    input logic [PRESC_W-1:0] presc,
                                    input logic               ext_fall,
                                    input logic               ext_rise);
    logic [3:0]         k;
    logic [PRESC_W-1:0] m;
    logic               t;
    k = 4'h0;
    m = '0;
    t = 1'b0;
    if (code == CODE_FALL) begin
      t = ext_fall;
    end else if (code == CODE_RISE) begin
      t = ext_rise;
    end else if (code == CODE_2FXX) begin
      t = ~oscillation_mode_bit;                      // prohibited when mcs is set
    end else if (code >= CODE_FXX) begin
      k = (code == CODE_TOP) ? TOP_EXP : 4'(code - CODE_FXX);
      k = 4'(k + {3'b000, ~oscillation_mode_bit});    // fxx is fx or fx/2
      m = PRESC_W'((13'h0001 << k) - 13'h0001);
      t = &(presc | ~m);
    end
    return t;
  endfunction : dtc_tick

endpackage : dtc_pkg

// File: core/dtc_channel.sv
// one 8-bit timer channel: counter, compare, output flip-flop and pwm
`timescale 1ns/1ps
module dtc_channel
  import dtc_pkg::*;
#(
  parameter int W = DATA_W
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         reset_i,
  // configuration
  input  wire dtc_mode_s    mode_i,
  input  wire logic [W-1:0] cmp_i,
  input  wire logic         ext_src_i,
  input  wire logic         pin_dir_out_i,
  input  wire logic         ff_set_i,
  input  wire logic         ff_clr_i,
  // count tick
  input  wire logic         tick_i,
  // results
  output logic      [W-1:0] count_o,
  output logic              irq_o,
  output logic              pin_o,
  output logic              pin_oe_o
);

  logic [W-1:0] cnt_q, cnt_d;
  logic         ff_q, ff_d;
  logic         irq_d, pin_d, oe_d;
  logic         equal, match, pwm_act;

  // compare against the counter on each tick
  assign equal   = (cnt_q == cmp_i);
  assign match   = mode_i.enable & tick_i & equal;
  assign irq_d   = match;

  // counter: cleared when stopped, cleared on match in interval mode
  assign cnt_d   = !mode_i.enable ? CNT_RST :
                   !tick_i        ? cnt_q :
                   (!mode_i.pwm_mode && equal) ? CNT_RST :
                   W'(cnt_q + 1'b1);

  // output flip-flop: direct set or reset, toggle on match in interval mode when alt level is set
  assign ff_d    = ff_set_i ? 1'b1 :
                   ff_clr_i ? 1'b0 :
                   (match & !mode_i.pwm_mode & mode_i.alt_level) ? ~ff_q :
                   ff_q;

  // pwm: active while count is below compare, level selectable
  assign pwm_act = (cnt_q < cmp_i);
  assign pin_d   = mode_i.pwm_mode ? (pwm_act ^ mode_i.alt_level)
                                   : ff_q;
  // no output while counting external edges
  assign oe_d    = mode_i.out_en & pin_dir_out_i & ~ext_src_i;

  // state and output registers
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cnt_q    <= CNT_RST;
      ff_q     <= 1'b0;
      irq_o    <= 1'b0;
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      ff_q     <= ff_d;
      irq_o    <= irq_d;
      pin_o    <= pin_d;
      pin_oe_o <= oe_d;
    end
  end

  assign count_o = cnt_q;

endmodule : dtc_channel

// File: core/dtc_timer.sv
// dual 8-bit timer/event counter with byte-wide register port
`timescale 1ns/1ps
//
// Overview of operation
// - each channel drives an 8-bit resolution pwm waveform on its output pin
// - counter equal to compare value raises that channel's match request
// - compare registers take any byte value and reset to 00H
// - counters count selected pulses, byte readable, reset to 00H
// - clock select holds 4-bit code in bits 3..0, upper bits zero
// - codes pick pin edges, 2fxx, fxx or fxx dividers; others prohibited
// - output pin unusable while counting external edges
// - port direction bits 0 and 1 govern the two output pins
// - fxx equals fx or fx/2, chosen by the oscillation mode bit
//
module dtc_timer
  import dtc_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  // register port
  input  wire logic [ADDR_W-1:0] bus_addr_i,
  input  wire logic              bus_wr_i,
  input  wire logic              bus_rd_i,
  input  wire logic [DATA_W-1:0] bus_wdata_i,
  output logic      [DATA_W-1:0] bus_rdata_o,
  // oscillation mode bit
  input  wire logic              oscillation_mode_bit_i,
  // event input pins
  input  wire logic              timer5_event_input_i,
  input  wire logic              timer6_event_input_i,
  // timer output pins
  output logic                   timer5_output_pin_o,
  output logic                   timer5_output_pin_oe_o,
  output logic                   timer6_output_pin_o,
  output logic                   timer6_output_pin_oe_o,
  // match requests
  output logic                   timer5_match_irq_o,
  output logic                   timer6_match_irq_o
);

  // software visible registers
  logic [DATA_W-1:0]  clk_sel_q  [NUM_CH];
  logic [DATA_W-1:0]  mode_q     [NUM_CH];
  logic [DATA_W-1:0]  cmp_q      [NUM_CH];
  logic [DATA_W-1:0]  pdir_q;
  logic [DATA_W-1:0]  rdata_d;
  logic [PRESC_W-1:0] presc_q;

  // per channel wires
  logic [NUM_CH-1:0]  ev_pin;
  logic [NUM_CH-1:0]  hit_tm, hit_cr, hit_tcl, hit_tmc;
  logic [NUM_CH-1:0]  wr_cr, wr_tcl, wr_tmc;
  logic [NUM_CH-1:0]  ext_fall, ext_rise, ext_src, tick;
  logic [NUM_CH-1:0]  irq, pin, pin_oe;
  logic [DATA_W-1:0]  count      [NUM_CH];
  logic [DATA_W-1:0]  rd_part    [NUM_CH];
  logic               hit_pdir;
  logic [NUM_CH-1:0]  ff_set, ff_clr;
  logic [DATA_W-1:0]  rd_or      [NUM_CH+1];

  localparam logic [15:0] TM_ADDR  [NUM_CH] = '{ADDR_TM5,  ADDR_TM6};
  localparam logic [15:0] CR_ADDR  [NUM_CH] = '{ADDR_CR5,  ADDR_CR6};
  localparam logic [15:0] TCL_ADDR [NUM_CH] = '{ADDR_TIMER5_CLOCK_SELECT, ADDR_TIMER6_CLOCK_SELECT};
  localparam logic [15:0] TMC_ADDR [NUM_CH] = '{ADDR_TIMER5_MODE_CONTROL, ADDR_TIMER6_MODE_CONTROL};

  // byte address match, shared by every register decode
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [15:0]       ra);
    return (a == ra);
  endfunction : reg_hit

  assign ev_pin   = {timer6_event_input_i, timer5_event_input_i};
  assign hit_pdir = reg_hit(bus_addr_i, ADDR_PDIR);
  assign rd_or[0] = RD_IDLE;

  // free running divider of the oscillator clock
  // one shared divider keeps the tick phase of both channels aligned
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      presc_q <= '0;
    end else begin
      presc_q <= PRESC_W'(presc_q + 1'b1);
    end
  end

  // port direction register, low two bits steer the output pins
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pdir_q <= PDIR_RST;
    end else if (bus_wr_i && hit_pdir) begin
      pdir_q <= bus_wdata_i;
    end
  end

  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic [2:0]      sync_q;
      logic            lvl_q;
      logic            lvl_d;
      logic [3:0]      code;
      dtc_mode_s       mode;

      // address decode for this channel
      assign hit_tm[c]  = reg_hit(bus_addr_i, TM_ADDR[c]);
      assign hit_cr[c]  = reg_hit(bus_addr_i, CR_ADDR[c]);
      assign hit_tcl[c] = reg_hit(bus_addr_i, TCL_ADDR[c]);
      assign hit_tmc[c] = reg_hit(bus_addr_i, TMC_ADDR[c]);
      assign wr_cr[c]   = bus_wr_i & hit_cr[c];
      assign wr_tcl[c]  = bus_wr_i & hit_tcl[c];
      assign wr_tmc[c]  = bus_wr_i & hit_tmc[c];

      // direct output flip-flop strobes, both bits together do nothing
      assign ff_set[c]  = wr_tmc[c] & bus_wdata_i[LVS_BIT]
                                    & ~bus_wdata_i[LVR_BIT];
      assign ff_clr[c]  = wr_tmc[c] & bus_wdata_i[LVR_BIT]
                                    & ~bus_wdata_i[LVS_BIT];

      // pin synchroniser, level accepted when stages two and three agree
      // a level caught mid change is held until both stages settle
      assign lvl_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : lvl_q;
      always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
          sync_q <= 3'b000;
          lvl_q  <= 1'b0;
        end else begin
          sync_q <= {sync_q[1:0], ev_pin[c]};
          lvl_q  <= lvl_d;
        end
      end
      assign ext_fall[c] = lvl_q & ~lvl_d;
      assign ext_rise[c] = ~lvl_q & lvl_d;

      // clock select register, upper nibble forced to zero
      always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
          clk_sel_q[c] <= TCL_RST;
        end else if (wr_tcl[c]) begin
          clk_sel_q[c] <= {4'h0, bus_wdata_i[CODE_MSB:0]};
        end
      end

      // mode register; set and reset bits act only as write pulses
      always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
          mode_q[c] <= TMC_RST;
        end else if (wr_tmc[c]) begin
          mode_q[c] <= bus_wdata_i & ~((8'h01 << LVS_BIT) |
                                       (8'h01 << LVR_BIT));
        end
      end

      // compare register, full byte range
      always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
          cmp_q[c] <= CMP_RST;
        end else if (wr_cr[c]) begin
          cmp_q[c] <= bus_wdata_i;
        end
      end

      // count clock selection
      assign code       = clk_sel_q[c][CODE_MSB:0];
      assign ext_src[c] = (code == CODE_FALL) | (code == CODE_RISE);
      assign tick[c]    = dtc_tick(code, oscillation_mode_bit_i,
                                   presc_q, ext_fall[c], ext_rise[c]);
      assign mode       = '{enable:    mode_q[c][TCE_BIT],
                            pwm_mode:  mode_q[c][PWM_BIT],
                            alt_level: mode_q[c][ALV_BIT],
                            out_en:    mode_q[c][TOE_BIT]};

      dtc_channel #(
        .W             (DATA_W)
      ) u_chan (
        .sys_clk_i     (sys_clk_i),
        .reset_i       (reset_i),
        .mode_i        (mode),
        .cmp_i         (cmp_q[c]),
        .ext_src_i     (ext_src[c]),
        .pin_dir_out_i (~pdir_q[c]),
        .ff_set_i      (ff_set[c]),
        .ff_clr_i      (ff_clr[c]),
        .tick_i        (tick[c]),
        .count_o       (count[c]),
        .irq_o         (irq[c]),
        .pin_o         (pin[c]),
        .pin_oe_o      (pin_oe[c])
      );

      // read contribution of this channel
      assign rd_part[c] = hit_tm[c]  ? count[c]     :
                          hit_cr[c]  ? cmp_q[c]     :
                          hit_tcl[c] ? clk_sel_q[c] :
                          hit_tmc[c] ? mode_q[c]    : RD_IDLE;
      // or-chain of the channel read parts
      assign rd_or[c+1] = rd_or[c] | rd_part[c];
    end
  endgenerate

  // read mux, unmapped addresses return zero
  assign rdata_d = hit_pdir ? pdir_q : rd_or[NUM_CH];

  // registered read data, loaded only on a read
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      bus_rdata_o <= RD_IDLE;
    end else if (bus_rd_i) begin
      bus_rdata_o <= rdata_d;
    end
  end

  // channel outputs are already flip-flops
  assign timer5_output_pin_o    = pin[0];
  assign timer5_output_pin_oe_o = pin_oe[0];
  assign timer6_output_pin_o    = pin[1];
  assign timer6_output_pin_oe_o = pin_oe[1];
  assign timer5_match_irq_o     = irq[0];
  assign timer6_match_irq_o     = irq[1];

endmodule : dtc_timer

// File: tb/dtc_pin_model.sv
// event pin model: each toggle request flips one pin level
`timescale 1ns/1ps
module dtc_pin_model (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  // requests and pins
  input  wire logic [1:0] toggle_i,
  output logic      [1:0] event_o
);
  // pins idle low, one edge per request
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      event_o <= 2'b00;
    end else begin
      event_o <= event_o ^ toggle_i;
    end
  end
endmodule : dtc_pin_model

// File: tb/dtc_timer_checker.sv
// assertions on the register port and channel five outputs
`timescale 1ns/1ps
module dtc_timer_checker
  import dtc_pkg::*;
(
  // clock and reset
  input wire logic              sys_clk_i,
  input wire logic              reset_i,
  // register port
  input wire logic [ADDR_W-1:0] bus_addr_i,
  input wire logic              bus_wr_i,
  input wire logic              bus_rd_i,
  input wire logic [DATA_W-1:0] bus_wdata_i,
  input wire logic [DATA_W-1:0] bus_rdata_o,
  // mode bit and channel five
  input wire logic              oscillation_mode_bit_i,
  input wire logic              timer5_output_pin_oe_o,
  input wire logic              timer5_match_irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  logic [7:0] cmp_q, tmc_q;
  logic [3:0] tcl_q;
  logic       pdir_q, ext, idle, oe_exp;
  // shadows of channel five writes
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cmp_q  <= CMP_RST;
      tmc_q  <= TMC_RST;
      tcl_q  <= 4'h0;
      pdir_q <= 1'b1;
    end else if (bus_wr_i) begin
      if (bus_addr_i == ADDR_CR5) cmp_q <= bus_wdata_i;
      if (bus_addr_i == ADDR_TIMER5_MODE_CONTROL) tmc_q <= bus_wdata_i;
      if (bus_addr_i == ADDR_TIMER5_CLOCK_SELECT) tcl_q <= bus_wdata_i[3:0];
      if (bus_addr_i == ADDR_PDIR) pdir_q <= bus_wdata_i[0];
    end
  end
  // pin source, silent codes and expected enable
  assign ext    = tcl_q <= CODE_RISE;
  assign idle   = tcl_q == 4'h2 || tcl_q == 4'h3 ||
                  (tcl_q == CODE_2FXX && oscillation_mode_bit_i);
  assign oe_exp = tmc_q[TOE_BIT] && !pdir_q && !ext;
  a_rd_hold_stable: assert property (
    !$past(bus_rd_i) |-> $stable(bus_rdata_o))
    else $error("read data moved without a read");
  a_tcl_read_back: assert property (
    bus_rd_i && bus_addr_i == ADDR_TIMER5_CLOCK_SELECT |=> bus_rdata_o == {4'h0, tcl_q})
    else $error("clock select readback wrong");
  a_cmp_read_back: assert property (
    bus_rd_i && bus_addr_i == ADDR_CR5 |=> bus_rdata_o == cmp_q)
    else $error("compare readback wrong");
  a_stop_count_zero: assert property (
    bus_rd_i && bus_addr_i == ADDR_TM5 && !tmc_q[TCE_BIT] &&
    !$past(tmc_q[TCE_BIT]) |=> bus_rdata_o == CNT_RST)
    else $error("stopped counter not zero");
  a_pdir_blocks_oe: assert property (
    $past(pdir_q) |-> !timer5_output_pin_oe_o)
    else $error("pin driven while direction is input");
  a_ext_blocks_oe: assert property (
    $past(ext) |-> !timer5_output_pin_oe_o)
    else $error("pin driven while counting pin edges");
  a_oe_follows_mode: assert property (
    $past(oe_exp) |-> timer5_output_pin_oe_o)
    else $error("pin not driven when enabled");
  a_no_tick_no_irq: assert property (
    $past(idle) |-> !timer5_match_irq_o)
    else $error("match raised without count clock");
  c_irq: cover property (timer5_match_irq_o);
  c_oe: cover property (timer5_output_pin_oe_o);
  c_idle: cover property (idle && tmc_q[TCE_BIT]);
endmodule : dtc_timer_checker

bind dtc_timer dtc_timer_checker u_chk (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .bus_addr_i(bus_addr_i),
  .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i),
  .bus_rdata_o(bus_rdata_o),
  .oscillation_mode_bit_i(oscillation_mode_bit_i),
  .timer5_output_pin_oe_o(timer5_output_pin_oe_o),
  .timer5_match_irq_o(timer5_match_irq_o)
);

// File: tb/tb_dtc_timer.sv
// self-checking bench: registers, count clocks, pin events, pwm
`timescale 1ns/1ps
module tb_dtc_timer;
  import dtc_pkg::*;
  logic [15:0] regs [7] = '{ADDR_TM5, ADDR_TM6, ADDR_CR5, ADDR_CR6,
                            ADDR_TIMER5_CLOCK_SELECT, ADDR_TIMER6_CLOCK_SELECT, 16'hFF00};
  logic        sys_clk_i = 1'b0;
  logic        reset_i   = 1'b1;
  logic [15:0] addr      = 16'h0000;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic [7:0]  wdata     = 8'h00;
  logic        oscillation_mode_bit       = 1'b0;
  logic [1:0]  tog       = 2'b00;
  logic [7:0]  rdata;
  logic [1:0]  ev, pin, oe, irq;
  int          fails = 0, n_compared = 0, seed = 34, cyc = 0;

  // clock and cycle ceiling
  always #2.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      stop_test();
    end
  end

  // design and pin partner
  dtc_timer dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .bus_addr_i(addr),
    .bus_wr_i(wr), .bus_rd_i(rd), .bus_wdata_i(wdata),
    .bus_rdata_o(rdata), .oscillation_mode_bit_i(oscillation_mode_bit),
    .timer5_event_input_i(ev[0]), .timer6_event_input_i(ev[1]),
    .timer5_output_pin_o(pin[0]), .timer5_output_pin_oe_o(oe[0]),
    .timer6_output_pin_o(pin[1]), .timer6_output_pin_oe_o(oe[1]),
    .timer5_match_irq_o(irq[0]), .timer6_match_irq_o(irq[1]));
  dtc_pin_model pins (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .toggle_i(tog), .event_o(ev));

  task automatic check(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  // byte write and byte read, one strobe cycle each
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk_i);
    wr    <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk_i);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rreg

  // count clock period in system cycles
  function automatic int period(input logic [3:0] c, input logic m);
    int e;
    e = (c == CODE_TOP) ? 11 : int'(c) - 5;
    return (c == CODE_2FXX) ? 1 : 1 << (e + (m ? 0 : 1));
  endfunction : period

  // cycles between two match pulses of a freshly started channel
  task automatic run_gap(input int ch, input logic [3:0] c, input logic m,
                         input logic [7:0] v);
    int g;
    wreg(ADDR_TIMER5_MODE_CONTROL + 16'(4 * ch), 8'h00);
    wreg(ADDR_TIMER5_CLOCK_SELECT + 16'(4 * ch), {4'h0, c});
    wreg(ADDR_CR5 + 16'(ch), v);
    @(posedge sys_clk_i);
    oscillation_mode_bit <= m;
    wreg(ADDR_TIMER5_MODE_CONTROL + 16'(4 * ch), 8'h80);
    for (int k = 0; k < 2; k++) begin
      g = 0;
      do begin
        @(posedge sys_clk_i);
        #1 g++;
      end while (irq[ch] !== 1'b1 && g < 20000);
    end
    check("match gap", 16'(g), 16'((v + 1) * period(c, m)));
  endtask : run_gap

  initial begin
    logic [7:0] d, v;
    int         k;
    repeat (6) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    // reset values, unmapped place, compare range, select width
    foreach (regs[i]) begin
      rreg(regs[i], d);
      check("reset value", d, 8'h00);
    end
    for (int i = 0; i < 8; i++) begin
      v = (i < 2) ? 8'hFF : 8'($random(seed));
      wreg(ADDR_CR5 + 16'(i % 2), v);
      rreg(ADDR_CR5 + 16'(i % 2), d);
      check("compare", d, v);
    end
    wreg(ADDR_TIMER5_CLOCK_SELECT, 8'hFF);
    rreg(ADDR_TIMER5_CLOCK_SELECT, d);
    check("clock select", d, 8'h0F);
    wreg(ADDR_TM5, 8'h5A);
    rreg(ADDR_TM5, d);
    check("count read only", d, 8'h00);
    // internal count clocks, every divider code
    run_gap(0, CODE_2FXX, 1'b0, 8'h00);
    for (int i = 0; i < 11; i++) begin
      v = (i > 4) ? 8'h00 : 8'($random(seed) & 3);
      run_gap(i % 2, 4'(5 + i), 1'($random(seed)), v);
    end
    // pin edge counting, falling then rising
    for (int i = 0; i < 4; i++) begin
      k = 1 + ($random(seed) & 3);
      wreg(ADDR_TIMER5_MODE_CONTROL + 16'(4 * (i % 2)), 8'h00);
      wreg(ADDR_TIMER5_CLOCK_SELECT + 16'(4 * (i % 2)), 8'(i / 2));
      wreg(ADDR_CR5 + 16'(i % 2), 8'hFF);
      wreg(ADDR_TIMER5_MODE_CONTROL + 16'(4 * (i % 2)), 8'h81);
      repeat (2 * k) begin
        @(posedge sys_clk_i);
        tog[i % 2] <= 1'b1;
        @(posedge sys_clk_i);
        tog[i % 2] <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
      end
      rreg(ADDR_TM5 + 16'(i % 2), d);
      check("event count", d, 8'(k));
    end
    // codes that never count
    @(posedge sys_clk_i);
    oscillation_mode_bit <= 1'b1;
    for (int i = 2; i < 5; i++) begin
      wreg(ADDR_TIMER5_MODE_CONTROL, 8'h00);
      wreg(ADDR_TIMER5_CLOCK_SELECT, 8'(i));
      wreg(ADDR_TIMER5_MODE_CONTROL, 8'h80);
      repeat (20) @(posedge sys_clk_i);
      rreg(ADDR_TM5, d);
      check("no count", d, 8'h00);
    end
    @(posedge sys_clk_i);
    oscillation_mode_bit <= 1'b0;
    // pwm duty, active high then low, and pin direction
    for (int i = 0; i < 2; i++) begin
      v = 8'($random(seed));
      wreg(ADDR_TIMER5_MODE_CONTROL + 16'(4 * i), 8'h00);
      wreg(ADDR_TIMER5_CLOCK_SELECT + 16'(4 * i), 8'h04);
      wreg(ADDR_CR5 + 16'(i), v);
      wreg(ADDR_PDIR, ~(8'h01 << i));
      wreg(ADDR_TIMER5_MODE_CONTROL + 16'(4 * i), 8'hC1 | 8'(i << 1));
      repeat (20) @(posedge sys_clk_i);
      k = 0;
      repeat (256) begin
        @(posedge sys_clk_i);
        #1 k += int'(pin[i] === 1'b1);
      end
      check("pwm duty", 16'(k), (i == 1) ? 16'(256 - v) : 16'(v));
      check("pin enable", oe[i], 1'b1);
      wreg(ADDR_PDIR, 8'hFF);
      repeat (2) @(posedge sys_clk_i);
      check("pin disable", oe[i], 1'b0);
    end
    stop_test();
  end
endmodule : tb_dtc_timer
